/* File: logic/cpps_params.svh */
// constants of the charge and power-path sequencer: timing counts and status codes
// assumes the sequencer clock runs at 20 MHz and all inputs are already synchronous
// ============================================================================
// Operation
// - at power up below precharge threshold, select precharge current level
// - precharge not past threshold within 30 minutes stops charge, reports fault
// - in voltage phase with valid timer pin, terminate on high feedback, low current
// - recharge threshold fall, power-on reset or enable toggle restart cycle, clear timer
// - timer pin low disables termination and safety timer, holds timer reset
// - timer pin at reference keeps termination but disables safety timer
// - end of overvoltage, low supply or sleep resets the safety timer
// - safety timer length is 5.6 minutes per nanofarad of timing setting
// - supply above battery sense: adapter switch on, battery off, then charge
// - battery sense above supply: battery switch on, enter sleep
// - under lockout stay disabled, adapter switch off, battery switch on
// - charge only with enable, no faults, regulators good, 30 ms after power up
// - stop charging on disable, removal, overvoltage, overload, overtemp, temp, timer; no overload input here, so overload does not stop charge
// - battery stays connected to load during power up and sleep
// - 30 ms after leaving sleep, disconnect battery then connect adapter
// - battery to adapter holds both switches off for 10 us first
// - after removal wait supply within 200 mV of battery, same dead time back
// - no adapter: adapter switch off, battery switch on
// ============================================================================
`ifndef CPPS_PARAMS_SVH
`define CPPS_PARAMS_SVH

`define CPPS_CLK_HZ          20000000
`define CPPS_DEAD_NS         10000
`define CPPS_DEAD_CYC        ((`CPPS_DEAD_NS * (`CPPS_CLK_HZ / 1000000) + 999) / 1000)
`define CPPS_PWRUP_MS        30
`define CPPS_PWRUP_CYC       (`CPPS_PWRUP_MS * (`CPPS_CLK_HZ / 1000))
`define CPPS_PRECHG_MIN      30
`define CPPS_PRECHG_CYC      (64'(`CPPS_PRECHG_MIN) * 60 * `CPPS_CLK_HZ)
`define CPPS_KTTC_DMIN_PER_NF 56
`define CPPS_MIN_CYC         (64'(60) * `CPPS_CLK_HZ)
`define CPPS_TTC_NF_DEFAULT  8'h0A
`define CPPS_CNT_W           40
`define CPPS_STAT_IDLE       2'h0
`define CPPS_STAT_CHARGE     2'h1
`define CPPS_STAT_DONE       2'h2
`define CPPS_STAT_FAULT      2'h3

`endif

/* File: logic/cpps_pkg.sv */
// types of the charge and power-path sequencer
// assumes cpps_params.svh is compiled alongside
package cpps_pkg;
	typedef enum logic [2:0] {
		CH_OFF, CH_PRE, CH_FAST, CH_DONE, CH_FAULT
	} cpps_chg_t;
	typedef enum logic [1:0] {
		SEL_BAT, SEL_DEAD_TO_AC, SEL_AC, SEL_DEAD_TO_BAT
	} cpps_sel_t;
	// comparator results, all already on the sequencer clock
	typedef struct packed {
		logic undervoltage_lockout;
		logic supply_low;
		logic sleep;
		logic near_bat;
		logic adapter_overvoltage;
		logic die_overtemperature;
		logic temp_fault;
		logic regs_good;
		logic below_pre;
		logic below_rech;
		logic fb_above_rech;
		logic i_below_term;
		logic volt_phase;
	} cpps_sense_t;
	typedef struct packed {
		logic tmr_pin_low;
		logic tmr_pin_ref;
	} cpps_tmr_mode_t;
endpackage

/* File: logic/cpps_delay.sv */
// terminal counter: counts while run, restarts when not running
// assumes a single clock domain
`include "cpps_params.svh"
module cpps_delay #(
	parameter int W = 40
) (
	input  wire logic         ref_clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         run_i,
	input  wire logic [W-1:0] limit_i,
	output logic              done_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} cpps_dly_st_t;
	cpps_dly_st_t st_r, st_nxt;

	// done sticks high while run holds, dropping run restarts the count
	always_comb begin
		st_nxt = st_r;
		if (!run_i) begin
			st_nxt.cnt  = '0;
			st_nxt.done = 1'b0;
		end else if (!st_r.done) begin
			if (st_r.cnt + W'(1) >= limit_i) st_nxt.done = 1'b1;
			st_nxt.cnt = st_r.cnt + W'(1);
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) st_r <= '0;
		else            st_r <= st_nxt;
	end
	assign done_o = st_r.done;
endmodule

/* File: logic/cpps_top.sv */
// charge sequencer and system power selector
// assumes comparator inputs are synchronous to ref_clk_i and gate outputs are active high
// (1 turns the switch on); the analog loops sit outside this block
`include "cpps_params.svh"
module cpps_top #(
	parameter longint PWRUP_CYC  = `CPPS_PWRUP_CYC,
	parameter longint PRECHG_CYC = `CPPS_PRECHG_CYC,
	parameter longint MIN_CYC    = `CPPS_MIN_CYC
) (
	input  wire logic                   ref_clk_i,
	input  wire logic                   reset_n_i,
	input  wire logic                   charge_enable_i,
	input  wire cpps_pkg::cpps_sense_t  sense_i,
	input  wire cpps_pkg::cpps_tmr_mode_t safety_timer_pin_i,
	input  wire logic [7:0]             ttc_nf_i,
	output logic                        charge_on_o,
	output logic                        precharge_term_level_o,
	output logic                        term_o,
	output logic                        fault_o,
	output logic [1:0]                  status_o,
	output logic                        adapter_switch_gate_o,
	output logic                        battery_switch_gate_o
);
	localparam int CW = `CPPS_CNT_W;

	// ========================================================================
	// state
	typedef struct packed {
		cpps_pkg::cpps_chg_t chg;
		cpps_pkg::cpps_sel_t sel;
		logic                ce_d;
		logic                abn_d;
		logic                pwrup_seen;
		logic [CW-1:0]       tmr;
		logic                chg_on;
		logic                pre_lvl;
		logic                term;
		logic                fault;
		logic [1:0]          status;
		logic                ac_gate;
		logic                bat_gate;
	} cpps_st_t;
	cpps_st_t st_r, st_nxt;

	// ========================================================================
	// delay counters
	logic pwrup_done, wake_done, dead_done, pre_done;
	logic wake_run, dead_run, pre_run;

	cpps_delay #(.W(CW)) u_pwrup (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.run_i     (1'b1),
		.limit_i   (CW'(PWRUP_CYC)),
		.done_o    (pwrup_done)
	);
	cpps_delay #(.W(CW)) u_wake (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.run_i     (wake_run),
		.limit_i   (CW'(PWRUP_CYC)),
		.done_o    (wake_done)
	);
	cpps_delay #(.W(CW)) u_dead (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.run_i     (dead_run),
		.limit_i   (CW'(`CPPS_DEAD_CYC)),
		.done_o    (dead_done)
	);
	cpps_delay #(.W(CW)) u_pre (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.run_i     (pre_run),
		.limit_i   (CW'(PRECHG_CYC)),
		.done_o    (pre_done)
	);

	// ========================================================================
	// qualifiers
	logic abnormal, adapter_ok, allow, stop, restart, tmr_en, tmr_limit_hit;
	logic [CW-1:0] tmr_limit;

	// overvoltage, low supply or sleep: resuming from any resets the timer
	assign abnormal   = sense_i.adapter_overvoltage | sense_i.supply_low | sense_i.sleep;
	assign adapter_ok = !sense_i.undervoltage_lockout && !sense_i.supply_low && !sense_i.sleep;
	// all enable conditions together
	assign allow = charge_enable_i && adapter_ok && !sense_i.adapter_overvoltage && !sense_i.die_overtemperature
		&& !sense_i.temp_fault && sense_i.regs_good && pwrup_done;
	assign stop = !allow;
	// enable toggle in either direction and a fall under recharge restart the cycle
	assign restart = (charge_enable_i != st_r.ce_d)
		|| (st_r.chg == cpps_pkg::CH_DONE && sense_i.below_rech);
	// pin low or at reference both turn the safety timer off
	assign tmr_en = !safety_timer_pin_i.tmr_pin_low && !safety_timer_pin_i.tmr_pin_ref;
	// limit is minutes per nanofarad, held in tenths of a minute
	assign tmr_limit = CW'(64'(ttc_nf_i) * `CPPS_KTTC_DMIN_PER_NF * MIN_CYC / 10);
	assign tmr_limit_hit = tmr_en && (st_r.tmr >= tmr_limit) && ttc_nf_i != 8'h00;

	assign wake_run = adapter_ok && st_r.sel == cpps_pkg::SEL_BAT;
	assign dead_run = st_r.sel == cpps_pkg::SEL_DEAD_TO_AC
		|| st_r.sel == cpps_pkg::SEL_DEAD_TO_BAT;
	assign pre_run  = st_r.chg == cpps_pkg::CH_PRE;

	// ========================================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.ce_d       = charge_enable_i;
		st_nxt.abn_d      = abnormal;
		st_nxt.pwrup_seen = pwrup_done;

		// safety timer: runs only while charging with the timer enabled
		if (!tmr_en || restart || (st_r.abn_d && !abnormal)) begin
			st_nxt.tmr = '0;
		end else if (st_r.chg == cpps_pkg::CH_PRE || st_r.chg == cpps_pkg::CH_FAST) begin
			st_nxt.tmr = st_r.tmr + CW'(1);
		end

		// power selector
		case (st_r.sel)
			cpps_pkg::SEL_BAT: begin
				if (wake_done) st_nxt.sel = cpps_pkg::SEL_DEAD_TO_AC;
			end
			cpps_pkg::SEL_DEAD_TO_AC: begin
				if (!adapter_ok) st_nxt.sel = cpps_pkg::SEL_BAT;
				else if (dead_done) st_nxt.sel = cpps_pkg::SEL_AC;
			end
			cpps_pkg::SEL_AC: begin
				// removal waits for supply near the battery; lockout or overvoltage leaves at once
				if ((sense_i.near_bat && !adapter_ok) || sense_i.undervoltage_lockout || sense_i.adapter_overvoltage)
					st_nxt.sel = cpps_pkg::SEL_DEAD_TO_BAT;
			end
			cpps_pkg::SEL_DEAD_TO_BAT: begin
				if (dead_done) st_nxt.sel = cpps_pkg::SEL_BAT;
			end
			default: st_nxt.sel = cpps_pkg::SEL_BAT;
		endcase
		if (sense_i.undervoltage_lockout) st_nxt.sel = cpps_pkg::SEL_BAT;

		// gate drive, battery on only in the battery state, both off in the dead states
		st_nxt.ac_gate  = st_nxt.sel == cpps_pkg::SEL_AC;
		st_nxt.bat_gate = st_nxt.sel == cpps_pkg::SEL_BAT;

		// charge sequence
		case (st_r.chg)
			cpps_pkg::CH_OFF: begin
				if (allow && st_r.sel == cpps_pkg::SEL_AC) begin
					if (sense_i.below_pre) st_nxt.chg = cpps_pkg::CH_PRE;
					else                   st_nxt.chg = cpps_pkg::CH_FAST;
				end
			end
			cpps_pkg::CH_PRE: begin
				if (stop || st_r.sel != cpps_pkg::SEL_AC) st_nxt.chg = cpps_pkg::CH_OFF;
				else if (pre_done) st_nxt.chg = cpps_pkg::CH_FAULT;
				else if (!sense_i.below_pre) st_nxt.chg = cpps_pkg::CH_FAST;
			end
			cpps_pkg::CH_FAST: begin
				if (stop || st_r.sel != cpps_pkg::SEL_AC) st_nxt.chg = cpps_pkg::CH_OFF;
				else if (tmr_limit_hit) st_nxt.chg = cpps_pkg::CH_FAULT;
				else if (!safety_timer_pin_i.tmr_pin_low && sense_i.volt_phase
					&& sense_i.fb_above_rech && sense_i.i_below_term)
					st_nxt.chg = cpps_pkg::CH_DONE;
			end
			cpps_pkg::CH_DONE: begin
				if (restart) st_nxt.chg = cpps_pkg::CH_OFF;
			end
			cpps_pkg::CH_FAULT: begin
				// a fault latches until a new cycle begins
				if (restart) st_nxt.chg = cpps_pkg::CH_OFF;
			end
			default: st_nxt.chg = cpps_pkg::CH_OFF;
		endcase
		if (restart && (st_r.chg == cpps_pkg::CH_PRE || st_r.chg == cpps_pkg::CH_FAST))
			st_nxt.chg = cpps_pkg::CH_OFF;

		// registered outputs
		st_nxt.chg_on  = st_nxt.chg == cpps_pkg::CH_PRE || st_nxt.chg == cpps_pkg::CH_FAST;
		st_nxt.pre_lvl = st_nxt.chg == cpps_pkg::CH_PRE;
		st_nxt.term    = st_nxt.chg == cpps_pkg::CH_DONE;
		st_nxt.fault   = st_nxt.chg == cpps_pkg::CH_FAULT;
		if (st_nxt.fault)       st_nxt.status = `CPPS_STAT_FAULT;
		else if (st_nxt.term)   st_nxt.status = `CPPS_STAT_DONE;
		else if (st_nxt.chg_on) st_nxt.status = `CPPS_STAT_CHARGE;
		else                    st_nxt.status = `CPPS_STAT_IDLE;
	end

	// register; reset acts as power-on reset and starts a fresh cycle with battery on
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r          <= '0;
			st_r.bat_gate <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign charge_on_o            = st_r.chg_on;
	assign precharge_term_level_o = st_r.pre_lvl;
	assign term_o                 = st_r.term;
	assign fault_o                = st_r.fault;
	assign status_o               = st_r.status;
	assign adapter_switch_gate_o  = st_r.ac_gate;
	assign battery_switch_gate_o  = st_r.bat_gate;

	// ========================================================================
	// checks
	chk_chg_allow: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(charge_on_o) |-> $past(allow))
		else $error("charge started without all enables");
	chk_gates_exclusive: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!(adapter_switch_gate_o && battery_switch_gate_o))
		else $error("both power switches on");
	chk_dead_time: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$fell(battery_switch_gate_o) && !sense_i.undervoltage_lockout |-> (!adapter_switch_gate_o) [*8])
		else $error("adapter switch on before dead time");
	chk_undervoltage_lockout_gates: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sense_i.undervoltage_lockout |=> !adapter_switch_gate_o && battery_switch_gate_o && !charge_on_o)
		else $error("lockout gates wrong");
	chk_tmr_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		safety_timer_pin_i.tmr_pin_low |=> st_r.tmr == '0)
		else $error("safety timer not held in reset");
	chk_no_term_low: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(term_o) |-> !$past(safety_timer_pin_i.tmr_pin_low))
		else $error("terminated with timer pin low");
	chk_precharge_lvl: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		precharge_term_level_o |-> charge_on_o && status_o == `CPPS_STAT_CHARGE)
		else $error("precharge level outside charge");
	chk_stop_ce: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		charge_on_o && !charge_enable_i |=> !charge_on_o)
		else $error("charge not stopped on disable");
	chk_fault_stat: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		fault_o |-> status_o == `CPPS_STAT_FAULT && !charge_on_o)
		else $error("fault status mismatch");
endmodule

/* File: dv/cpps_far_model.sv */
// far-side power path: adapter and battery switches feeding the system rail
// assumes gate inputs are active high (1 = switch on) and one clock domain
module cpps_far_model (
	input  wire logic ref_clk_i,
	input  wire logic reset_n_i,
	input  wire logic adapter_switch_gate_i,
	input  wire logic battery_switch_gate_i,
	output logic      overlap_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ========================================================================
	// shoot-through watch
	// sticky, so a single overlapping cycle is never lost between checks
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overlap_o <= 1'b0;
		end else if (adapter_switch_gate_i && battery_switch_gate_i) begin
			overlap_o <= 1'b1;
		end
	end
endmodule

/* File: dv/charge_power_path_sequencer_tb.sv */
// self-checking bench for the charge sequencer and power selector
// assumes cpps_pkg and cpps_params.svh are compiled first
`include "cpps_params.svh"
module charge_power_path_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// short counts keep the run small; expectations derive from these
	localparam longint PU = 20, PC = 200, MC = 10;
	localparam int DEAD = 10000 / 50; // 10 us at 50 ns
	logic ref_clk_i = 1'b0, reset_n_i = 1'b0, en = 1'b0;
	cpps_pkg::cpps_sense_t s = '0;
	cpps_pkg::cpps_tmr_mode_t tp = '0;
	logic [7:0] nf = 8'h00;
	logic chg, pre, term, flt, ac, bat, ovl;
	logic [1:0] st;
	logic [31:0] rs = 32'h59DBE7C8;
	int errors = 0, n_tests = 0, n, k, e;
	cpps_top #(.PWRUP_CYC(PU), .PRECHG_CYC(PC), .MIN_CYC(MC)) dut_u (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .charge_enable_i(en), .sense_i(s),
		.safety_timer_pin_i(tp), .ttc_nf_i(nf), .charge_on_o(chg),
		.precharge_term_level_o(pre), .term_o(term), .fault_o(flt), .status_o(st),
		.adapter_switch_gate_o(ac), .battery_switch_gate_o(bat));
	cpps_far_model far_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.adapter_switch_gate_i(ac), .battery_switch_gate_i(bat), .overlap_o(ovl));
	// ========================================================================
	// helpers
	initial begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(string nm, logic [31:0] ex, logic [31:0] g);
		n_tests++;
		if (g !== ex) begin
			errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, ex, g);
		end
	endtask
	function automatic logic pick(int sel);
		case (sel)
			0: return chg;
			1: return flt;
			2: return ac;
			3: return term;
			default: return bat;
		endcase
	endfunction
	// bounded wait for an output level, returns cycles spent
	task automatic wt(int sel, logic v, int lim, output int c);
		c = 0;
		while (c < lim && pick(sel) !== v) begin
			@(posedge ref_clk_i);
			#1;
			c++;
		end
	endtask
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic toggle_en();
		@(posedge ref_clk_i);
		en <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		en <= 1'b1;
	endtask
	task automatic end_of_test();
		if (errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ========================================================================
	// watchdog: whole sequence needs under 1,500 cycles
	initial begin
		#(50 * 20000);
		errors++;
		end_of_test();
	end
	// ========================================================================
	// main sequence
	initial begin
		repeat (4) @(posedge ref_clk_i);
		#1;
		chk("bat_in_reset", 1, bat);
		chk("ac_in_reset", 0, ac);
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		s.regs_good <= 1'b1;
		s.below_pre <= 1'b1;
		en <= 1'b1;
		wt(4, 1'b0, 40, n);
		chk("wake_delay", 1, n >= PU && n <= PU + 3);
		chk("ac_in_dead", 0, ac);
		wt(2, 1'b1, DEAD + 20, n);
		chk("dead_cycles", 1, n >= DEAD - 1 && n <= DEAD + 1);
		wt(0, 1'b1, 5, n);
		chk("chg_on", 1, chg);
		chk("pre_level", 1, pre);
		// precharge that never passes the threshold
		wt(1, 1'b1, PC + 20, n);
		chk("pre_timeout", 1, n >= PC - 3 && n <= PC + 3);
		chk("chg_off_flt", 0, chg);
		chk("st_fault", `CPPS_STAT_FAULT, st);
		s.below_pre <= 1'b0;
		toggle_en();
		wt(0, 1'b1, 10, n);
		chk("flt_clear", 0, flt);
		chk("fast_level", 0, pre);
		// termination masked, then allowed
		tp.tmr_pin_low <= 1'b1;
		s.volt_phase <= 1'b1;
		s.fb_above_rech <= 1'b1;
		s.i_below_term <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		#1;
		chk("term_masked", 0, term);
		tp.tmr_pin_low <= 1'b0;
		wt(3, 1'b1, 10, n);
		chk("term", 1, term);
		chk("st_done", `CPPS_STAT_DONE, st);
		s.fb_above_rech <= 1'b0;
		s.below_rech <= 1'b1;
		wt(0, 1'b1, 10, n);
		chk("recharge", 1, chg);
		s.below_rech <= 1'b0;
		// safety timer, random setting of 1..3 nF
		k = 1 + xs() % 3;
		e = k * 56 * MC / 10;
		nf <= k[7:0];
		s.volt_phase <= 1'b0;
		toggle_en();
		wt(0, 1'b1, 10, n);
		wt(1, 1'b1, e + 20, n);
		chk("timer_len", 1, n >= e - 4 && n <= e + 4);
		tp.tmr_pin_ref <= 1'b1;
		toggle_en();
		repeat (e + 50) @(posedge ref_clk_i);
		#1;
		chk("timer_off", 0, flt);
		chk("chg_ref", 1, chg);
		tp.tmr_pin_ref <= 1'b0;
		nf <= 8'h00;
		// stop conditions in random order
		k = xs() % 2;
		for (int i = 0; i < 2; i++) begin
			s[((i + k) % 2) ? 7 : 6] <= 1'b1;
			wt(0, 1'b0, 5, n);
			chk("stop", 0, chg);
			s[((i + k) % 2) ? 7 : 6] <= 1'b0;
			wt(0, 1'b1, 10, n);
			chk("resume", 1, chg);
		end
		s.adapter_overvoltage <= 1'b1;
		wt(4, 1'b1, DEAD + 20, n);
		chk("adapter_overvoltage_bat", 1, bat);
		chk("adapter_overvoltage_chg", 0, chg);
		s.adapter_overvoltage <= 1'b0;
		wt(2, 1'b1, PU + DEAD + 20, n);
		chk("reconnect", 1, ac);
		s.sleep <= 1'b1;
		s.near_bat <= 1'b1;
		wt(4, 1'b1, DEAD + 20, n);
		chk("sleep_bat", 1, bat);
		chk("sleep_ac", 0, ac);
		chk("sleep_chg", 0, chg);
		chk("overlap", 0, ovl);
		end_of_test();
	end
endmodule
